//--- hw/fsl_top.sv
// fsl_top: fault status logic inside the sequence controller
// assumes decoded commands, words and error strobes arrive synchronous to clk_i
`timescale 1ns/1ps
module fsl_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_addressed_i,
  input wire logic [3:0] cmd_mode_i,
  input wire logic [5:0] cmd_words_i,
  input wire logic data_word_i,
  input wire logic op_done_i,
  input wire logic power_event_i,
  input wire logic power_up_i,
  input wire logic selftest_pass_i,
  input wire logic in_data_err_i,
  input wire logic no_channel_i,
  input wire logic no_module_i,
  input wire logic dual_bus_i,
  input wire logic illegal_mode_i,
  input wire logic internal_err_i,
  input wire logic gap_err_i,
  input wire logic test_ok_i,
  input wire logic [4:0] subtest_i,
  input wire logic resp_active_i,
  input wire logic [fsl_pkg::FSL_RESP_WIDTH-1:0] resp_word_i,
  output logic [fsl_pkg::FSL_RESP_WIDTH-1:0] resp_word_o,
  output logic resp_valid_o,
  output logic [fsl_pkg::FSL_WIDTH-1:0] status_word_o,
  output logic status_valid_o,
  output logic [3:0] test_start_o,
  output logic module_reset_o,
  output logic receiver_en_o,
  output logic busy_o
);
  import fsl_pkg::*;

  fsl_evt_if evt ();
  fsl_flags u_flags (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .evt(evt)
  );

  fsl_state_t state;
  logic [5:0] words_left;
  logic rx_enabled;
  logic surplus;
  logic overlap;
  logic start;

  //////////////////////////////////////////////////////////////////////
  // event collection
  assign start = cmd_valid_i && cmd_addressed_i && rx_enabled;
  assign surplus = data_word_i && rx_enabled && (state != FSL_BUSY || words_left == 6'h00);
  assign overlap = cmd_valid_i && rx_enabled && state == FSL_BUSY && !op_done_i;

  always_comb begin
    evt.set = '0;
    evt.set[FSL_POWER] = power_event_i;
    evt.set[FSL_IN_ERR] = in_data_err_i;
    evt.set[FSL_NO_CHAN] = no_channel_i;
    evt.set[FSL_NO_IOM] = no_module_i;
    evt.set[FSL_TOO_MANY] = surplus;
    evt.set[FSL_OVERRUN] = overlap;
    evt.set[FSL_DUAL_BUS] = dual_bus_i;
    evt.set[FSL_ILLEGAL] = illegal_mode_i;
    evt.set[FSL_INTERNAL] = internal_err_i;
    evt.set[FSL_GAP] = gap_err_i;
    evt.set[FSL_TEST_OK] = test_ok_i;
    evt.set[FSL_WIDTH-1:FSL_TEST_OK+1] = subtest_i;
  end

  // read-clear happens only on the status mode command
  assign evt.clear = ce_i && start && cmd_mode_i == FSL_MODE_STATUS_READ;

  //////////////////////////////////////////////////////////////////////
  // receiver gating after power up
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_enabled <= 1'b0;
    end else if (ce_i) begin
      if (power_event_i && power_up_i) begin
        rx_enabled <= 1'b0;
      end else if (selftest_pass_i) begin
        rx_enabled <= 1'b1;
      end
    end
  end
  assign receiver_en_o = rx_enabled;

  //////////////////////////////////////////////////////////////////////
  // command sequencing
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= FSL_IDLE;
      words_left <= 6'h00;
    end else if (ce_i) begin
      if (start) begin
        // a new addressed command abandons any running one
        state <= FSL_BUSY;
        words_left <= cmd_words_i;
      end else if (dual_bus_i || illegal_mode_i || gap_err_i) begin
        state <= FSL_HALT;
      end else begin
        unique case (state)
          FSL_IDLE: begin
          end
          FSL_BUSY: begin
            if (op_done_i) begin
              state <= FSL_IDLE;
            end else if (data_word_i && words_left != 6'h00) begin
              words_left <= words_left - 6'h01;
            end else if (surplus) begin
              state <= FSL_IDLE;
            end
          end
          FSL_HALT: begin
          end
        endcase
      end
    end
  end
  assign busy_o = (state == FSL_BUSY);

  //////////////////////////////////////////////////////////////////////
  // status response and test launch
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      status_word_o <= FSL_RESET_VALUE;
      status_valid_o <= 1'b0;
      test_start_o <= 4'h0;
    end else if (ce_i) begin
      status_valid_o <= evt.clear;
      if (evt.clear) begin
        status_word_o <= evt.flags;
      end
      test_start_o <= 4'h0;
      if (start) begin
        test_start_o[0] <= cmd_mode_i == FSL_MODE_CTRL_TEST;
        test_start_o[1] <= cmd_mode_i == FSL_MODE_CONV_TEST;
        test_start_o[2] <= cmd_mode_i == FSL_MODE_PSU_TEST;
        test_start_o[3] <= cmd_mode_i == FSL_MODE_IOM_TEST;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // response word path; validity bit is the top bit
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      resp_word_o <= '0;
      resp_valid_o <= 1'b0;
      module_reset_o <= 1'b0;
    end else if (ce_i) begin
      module_reset_o <= power_event_i;
      resp_valid_o <= resp_active_i;
      resp_word_o <= resp_word_i;
      if (no_channel_i || no_module_i) begin
        resp_word_o[FSL_RESP_BIT25] <= 1'b0;
      end
      if (power_event_i && resp_active_i) begin
        resp_word_o[FSL_RESP_BIT25] <= 1'b0;
      end
    end
  end
endmodule // fsl_top

//--- hw/fsl_pkg.sv
// fault status logic package: status bit positions, mode codes, request layout
// assumes a decoded command stream from the bus interface adapter
package fsl_pkg;
  localparam int FSL_WIDTH = 16;
  localparam logic [3:0] FSL_MODE_STATUS_READ = 4'hA;
  localparam logic [3:0] FSL_MODE_CTRL_TEST = 4'h4;
  localparam logic [3:0] FSL_MODE_CONV_TEST = 4'h5;
  localparam logic [3:0] FSL_MODE_PSU_TEST = 4'h6;
  localparam logic [3:0] FSL_MODE_IOM_TEST = 4'h7;
  // flag positions, bit n of the table sits at index n-1
  localparam int FSL_POWER = 0;
  localparam int FSL_IN_ERR = 1;
  localparam int FSL_NO_CHAN = 2;
  localparam int FSL_NO_IOM = 3;
  localparam int FSL_TOO_MANY = 4;
  localparam int FSL_OVERRUN = 5;
  localparam int FSL_DUAL_BUS = 6;
  localparam int FSL_ILLEGAL = 7;
  localparam int FSL_INTERNAL = 8;
  localparam int FSL_GAP = 9;
  localparam int FSL_TEST_OK = 10;
  localparam logic [FSL_WIDTH-1:0] FSL_RESET_VALUE = 16'h0000;
  // response bit that drops on a power event while resp_active_i is high, and on no_channel_i or no_module_i
  localparam int FSL_RESP_BIT25 = 24;
  localparam int FSL_RESP_WIDTH = 25;
  // ground request layout (host side builds it)
  localparam logic [6:0] FSL_OP_TEST_READ = 7'h2C;
  localparam logic [6:0] FSL_UNIT_ADDR_A = 7'h0D;
  localparam logic [6:0] FSL_UNIT_ADDR_B = 7'h0E;
  typedef enum logic [1:0] {FSL_IDLE, FSL_BUSY, FSL_HALT} fsl_state_t;
endpackage

//--- hw/fsl_evt_if.sv
// fsl_evt_if: event carrier between the latch and the controller
// assumes one clock domain
`timescale 1ns/1ps
interface fsl_evt_if;
  logic [15:0] set;
  logic clear;
  logic [15:0] flags;
  modport ctrl (output set, output clear, input flags);
  modport latch (input set, input clear, output flags);
endinterface

//--- hw/fsl_flags.sv
// fsl_flags: sticky fault status register
// assumes set and clear are synchronous to clk_i
`timescale 1ns/1ps
module fsl_flags (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  fsl_evt_if.latch evt
);
  import fsl_pkg::*;
  logic [FSL_WIDTH-1:0] flags;
  // set wins over the read-clear so no event slips between reads
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flags <= FSL_RESET_VALUE;
    end else if (ce_i) begin
      flags <= (evt.clear ? FSL_RESET_VALUE : flags) | evt.set;
    end
  end
  assign evt.flags = flags;
endmodule // fsl_flags

//--- testbench/fsl_host_model.sv
// host model: issues decoded command words to the fault status logic
// assumes clk_i is the block clock
`timescale 1ns/1ps
module fsl_host_model (
  input wire logic clk_i,
  output logic cmd_valid_o,
  output logic cmd_addressed_o,
  output logic [3:0] cmd_mode_o
);
  import fsl_pkg::*;
  localparam logic [2:0] VEHICLE_ID = 3'h2; // arbitrary value
  localparam logic [3:0] MAJOR_FN = 4'h8;
  // ground request, bit 1 of the layout is the msb
  function automatic logic [47:0] build_req(input logic [3:0] module_num, input logic [1:0] chan,
                                            input logic [6:0] unit, input logic xfer, input logic [3:0] param);
    build_req = {VEHICLE_ID, MAJOR_FN, FSL_OP_TEST_READ, 1'b1, 1'b1, module_num, 3'h0, chan, unit, xfer,
                 11'h000, param};
  endfunction
  initial begin
    cmd_valid_o = 1'b0;
    cmd_addressed_o = 1'b0;
    cmd_mode_o = 4'h0;
  end
  // released fields show the inverse, not the last value
  task send(input logic [3:0] mode);
    @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_addressed_o = 1'b1;
    cmd_mode_o = mode;
    @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b0;
    cmd_addressed_o = 1'b0;
    cmd_mode_o = ~mode;
  endtask
endmodule // fsl_host_model

//--- testbench/fsl_top_chk.sv
// checker: port rules of the fault status logic
// assumes it is bound to fsl_top, one clock
`timescale 1ns/1ps
module fsl_top_chk (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_addressed_i,
  input wire logic [3:0] cmd_mode_i,
  input wire logic power_event_i,
  input wire logic power_up_i,
  input wire logic no_channel_i,
  input wire logic resp_active_i,
  input wire logic [fsl_pkg::FSL_RESP_WIDTH-1:0] resp_word_o,
  input wire logic [fsl_pkg::FSL_WIDTH-1:0] status_word_o,
  input wire logic status_valid_o,
  input wire logic [3:0] test_start_o,
  input wire logic module_reset_o,
  input wire logic receiver_en_o
);
  import fsl_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire logic take = ce_i && cmd_valid_i && cmd_addressed_i && receiver_en_o;
  wire logic rd = take && cmd_mode_i == FSL_MODE_STATUS_READ;
  read_served_a: assert property (rd |=> status_valid_o) else $error("read not served");
  read_cause_a: assert property (status_valid_o |-> $past(rd)) else $error("stray read");
  snap_hold_a: assert property (!status_valid_o |-> $stable(status_word_o)) else $error("word moved");
  flag_seen_a: assert property ((ce_i && no_channel_i) ##1 rd |=> status_word_o[FSL_NO_CHAN])
    else $error("flag lost");
  ctrl_test_a: assert property (take && cmd_mode_i == FSL_MODE_CTRL_TEST |=> test_start_o == 4'h1)
    else $error("test start");
  refuse_a: assert property (ce_i && cmd_valid_i && !receiver_en_o |=> !status_valid_o)
    else $error("not refused");
  mod_reset_a: assert property (ce_i && power_event_i |=> module_reset_o) else $error("no reset");
  rx_off_a: assert property (ce_i && power_event_i && power_up_i |=> !receiver_en_o)
    else $error("rx on");
  vbit_a: assert property (ce_i && resp_active_i && no_channel_i |=> !resp_word_o[FSL_RESP_BIT25])
    else $error("vbit");
endmodule // fsl_top_chk
bind fsl_top fsl_top_chk fsl_top_chk_inst (.*);

//--- testbench/tb_top.sv
// testbench: status reads, self-test modes, power events
// assumes host model and checker files compiled first
`timescale 1ns/1ps
module tb_top;
  import fsl_pkg::*;
  logic clk_i = 0, reset_i = 1, ce_i = 1, op_done_i = 0, power_event_i = 0, power_up_i = 0, selftest_pass_i = 0;
  logic resp_active_i = 1;
  logic [5:0] cmd_words_i = 6'h00;
  logic [4:0] subtest_i = 5'h00;
  logic [8:0] err = 9'h000;
  logic [FSL_RESP_WIDTH-1:0] resp_word_i = '1, resp_word_o;
  wire logic cmd_valid_i, cmd_addressed_i, data_word_i, test_ok_i, gap_err_i, internal_err_i;
  wire logic illegal_mode_i, dual_bus_i, no_module_i, no_channel_i, in_data_err_i;
  wire logic [3:0] cmd_mode_i;
  logic resp_valid_o, status_valid_o, module_reset_o, receiver_en_o, busy_o;
  logic [FSL_WIDTH-1:0] status_word_o;
  logic [3:0] test_start_o;
  logic [47:0] req;
  int err_count = 0, n_compared = 0;
  int pos[9] = '{FSL_IN_ERR, FSL_NO_CHAN, FSL_NO_IOM, FSL_DUAL_BUS, FSL_ILLEGAL, FSL_INTERNAL, FSL_GAP,
                 FSL_TEST_OK, FSL_TOO_MANY};
  assign {data_word_i, test_ok_i, gap_err_i, internal_err_i, illegal_mode_i, dual_bus_i, no_module_i,
          no_channel_i, in_data_err_i} = err;
  fsl_top fsl_top_inst (.*);
  fsl_host_model fsl_host_model_inst (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i), .cmd_addressed_o(cmd_addressed_i),
    .cmd_mode_o(cmd_mode_i));
  ////////////////////////////////////////
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task tick;
    @(posedge clk_i);
    #1;
  endtask
  task rd(input logic [15:0] exp);
    fsl_host_model_inst.send(FSL_MODE_STATUS_READ);
    chk("status_valid", status_valid_o, 16'h0001);
    chk("status_word", status_word_o, exp);
    chk("busy", busy_o, 16'h0001);
    op_done_i = 1;
    tick;
    op_done_i = 0;
    chk("busy", busy_o, 16'h0000);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) tick;
    reset_i = 0;
    chk("rx_en", receiver_en_o, 16'h0000);
    fsl_host_model_inst.send(FSL_MODE_STATUS_READ);
    chk("refused", status_valid_o, 16'h0000);
    selftest_pass_i = 1;
    tick;
    selftest_pass_i = 0;
    chk("rx_en", receiver_en_o, 16'h0001);
    rd(16'h0000);
    // idle gap before each read shows the flag is held
    foreach (pos[i]) begin
      err = 9'h001 << i;
      tick;
      err = 9'h000;
      tick;
      rd(16'h0001 << pos[i]);
      rd(16'h0000);
    end
    for (int m = 4; m < 8; m++) begin
      fsl_host_model_inst.send(4'(m));
      chk("test_start", test_start_o, 16'h0001 << (m - 4));
      op_done_i = 1;
      tick;
      op_done_i = 0;
    end
    rd(16'h0000);
    fsl_host_model_inst.send(FSL_MODE_CTRL_TEST);
    rd(16'h0000);
    rd(16'h0001 << FSL_OVERRUN);
    power_event_i = 1;
    power_up_i = 1;
    tick;
    power_event_i = 0;
    power_up_i = 0;
    chk("module_reset", module_reset_o, 16'h0001);
    chk("resp_vbit", resp_word_o[FSL_RESP_BIT25], 16'h0000);
    chk("resp_valid", resp_valid_o, 16'h0001);
    chk("rx_en", receiver_en_o, 16'h0000);
    selftest_pass_i = 1;
    tick;
    selftest_pass_i = 0;
    rd(16'h0001 << FSL_POWER);
    req = fsl_host_model_inst.build_req(4'h3, 2'h2, FSL_UNIT_ADDR_A, 1'b0, 4'hA);
    chk("req_op", req[40:34], 16'h002C);
    chk("req_first_last", req[33:32], 16'h0003);
    chk("req_module_chan", req[31:23], 16'h0062);
    chk("req_unit", req[22:16], 16'h000D);
    chk("req_tail", req[15:0], 16'h000A);
    end_sim;
  end
  initial begin
    #40000;
    err_count++;
    end_sim;
  end
endmodule // tb_top
